// *** rtl/wdse_pkg.sv ***
`default_nettype none
package wdse_pkg;
	// core clock and watchdog source oscillator
	localparam int unsigned CLK_HZ   = 100_000_000;
	localparam int unsigned LOW_POWER_RC_OSC_HZ  = 32_000;
	localparam int unsigned LOW_POWER_RC_OSC_DIV = CLK_HZ / LOW_POWER_RC_OSC_HZ;
	localparam logic [11:0] LOW_POWER_RC_OSC_LAST = 12'(LOW_POWER_RC_OSC_DIV - 1);

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CONFIG     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 4'hc;

	// reset_control_reg fields
	localparam int unsigned RC_IDLE  = 2;
	localparam int unsigned RC_SLEEP = 3;
	localparam int unsigned RC_WD_TIMEOUT_FLAG  = 4;
	localparam int unsigned RC_SWEN  = 5;

	// wd_config_word fields
	localparam int unsigned CF_POST_LSB = 0;
	localparam int unsigned CF_PRE      = 4;
	localparam int unsigned CF_WINDOW_DISABLE   = 7;
	localparam int unsigned CF_WIN_LSB  = 8;
	localparam int unsigned CF_EN_LSB   = 12;
	localparam logic [DATA_W-1:0] CONFIG_RST = 16'h209f;

	localparam logic [1:0] EN_ALWAYS = 2'h3;
	localparam logic [1:0] EN_SOFT   = 2'h2;
	localparam logic [6:0] PRE32_LAST  = 7'h1f;
	localparam logic [6:0] PRE128_LAST = 7'h7f;

	// interrupt status / mask layout
	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_TIMEOUT = 0;
	localparam int unsigned IRQ_WAKE    = 1;
	localparam int unsigned IRQ_EARLY   = 2;

	typedef enum logic [2:0] {
		MODE_RUN   = 3'h1,
		MODE_IDLE  = 3'h2,
		MODE_SLEEP = 3'h4
	} wdse_mode_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} wdse_bus_req_type;

	typedef struct packed {
		logic clear_wd_instr;
		logic power_save_instr;
		logic power_save_sleep;
		logic wake_event;
		logic clk_switch_done;
		logic dev_reset;
	} wdse_core_evt_type;
endpackage
`default_nettype wire

// *** rtl/wdse_watchdog.sv ***
`default_nettype none
module wdse_watchdog (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire wdse_pkg::wdse_bus_req_type bus_req,
	output var  logic [wdse_pkg::DATA_W-1:0] bus_rdata,
	input  wire wdse_pkg::wdse_core_evt_type core_evt,
	output var  logic                      wd_reset_req,
	output var  logic                      wd_wake,
	output var  logic                      osc_enable,
	output var  logic                      low_power,
	output var  logic                      irq
);
	import wdse_pkg::*;

	typedef struct packed {
		wdse_mode_type     mode;
		logic [11:0]       div;
		logic [6:0]        pre;
		logic [14:0]       post;
		logic [DATA_W-1:0] cfg;
		logic              swen;
		logic              wd_timeout_flag;
		logic              slp;
		logic              idl;
		logic [IRQ_W-1:0]  stat;
		logic [IRQ_W-1:0]  mask;
		logic [DATA_W-1:0] rdata;
		logic              irq;
		logic              rst_req;
		logic              wake;
		logic              osc_en;
		logic              low;
	} wdse_state_type;

	wdse_state_type s_q;
	wdse_state_type s_d;

	////////////////////////////////////////////////////////////////////////////////
	// window opens at a quarter step of the period; sel 3 leaves it always open

	function automatic logic [14:0] wdse_win_start(input logic [1:0]  sel,
	                                               input logic [14:0] last);
		logic [15:0] quarter;
		quarter = (16'(last) + 16'h1) >> 2;
		case (sel)
			2'h0:    wdse_win_start = 15'(quarter * 16'h3);
			2'h1:    wdse_win_start = 15'(quarter * 16'h2);
			2'h2:    wdse_win_start = quarter[14:0];
			default: wdse_win_start = 15'h0;
		endcase
	endfunction

	function automatic logic wdse_addr_is(input logic [ADDR_W-1:0] a,
	                                      input logic [ADDR_W-1:0] ofs);
		wdse_addr_is = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// derived terms

	logic [1:0]  en_cfg;
	logic        en;
	logic        run;
	logic        low_power_rc_osc_tick;
	logic [6:0]  pre_last;
	logic        pre_tick;
	logic [14:0] period_last;
	logic        win_open;
	logic        timeout;
	logic        early;
	logic        restart;
	logic        wr_rc;
	logic        wr_stat;
	logic [IRQ_W-1:0] evt_bits;

	assign en_cfg = s_q.cfg[CF_EN_LSB +: 2];
	// any code other than the two enable codes leaves the watchdog off
	assign en = (en_cfg == EN_ALWAYS) || ((en_cfg == EN_SOFT) && s_q.swen);
	assign run = (s_q.mode == MODE_RUN);
	// the oscillator is modelled as a tick every LOW_POWER_RC_OSC_DIV core cycles
	assign low_power_rc_osc_tick = en && (s_q.div == LOW_POWER_RC_OSC_LAST);
	assign pre_last = s_q.cfg[CF_PRE] ? PRE128_LAST : PRE32_LAST;
	assign pre_tick = low_power_rc_osc_tick && (s_q.pre == pre_last);
	assign period_last = 15'((16'h1 << s_q.cfg[CF_POST_LSB +: 4]) - 16'h1);
	assign win_open = (s_q.post >= wdse_win_start(s_q.cfg[CF_WIN_LSB +: 2], period_last));
	assign timeout = pre_tick && (s_q.post == period_last);
	// a clear before the window opens is treated like a time-out
	assign early = en && run && core_evt.clear_wd_instr && !s_q.cfg[CF_WINDOW_DISABLE]
	               && !win_open;
	assign restart = core_evt.dev_reset || core_evt.clk_switch_done || timeout || early || !en
	                 || (run && (core_evt.clear_wd_instr || core_evt.power_save_instr))
	                 || (!run && core_evt.wake_event);
	assign wr_rc = bus_req.wr && wdse_addr_is(bus_req.addr, OFS_RESET_CTRL);
	assign wr_stat = bus_req.wr && wdse_addr_is(bus_req.addr, OFS_INT_STAT);
	assign evt_bits = {early, timeout && !run, timeout};

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;

		// counting carries on in every mode while enabled
		if (restart) begin
			s_d.div = 12'h0;
			s_d.pre = 7'h0;
			s_d.post = 15'h0;
		end else if (en) begin
			s_d.div = low_power_rc_osc_tick ? 12'h0 : s_q.div + 12'h1;
			if (low_power_rc_osc_tick) begin
				s_d.pre = pre_tick ? 7'h0 : s_q.pre + 7'h1;
			end
			if (pre_tick) begin
				s_d.post = s_q.post + 15'h1;
			end
		end

		unique case (s_q.mode)
			MODE_RUN: begin
				if (core_evt.power_save_instr) begin
					s_d.mode = core_evt.power_save_sleep ? MODE_SLEEP : MODE_IDLE;
				end
			end
			MODE_IDLE, MODE_SLEEP: begin
				if (timeout || core_evt.wake_event) begin
					s_d.mode = MODE_RUN;
				end
			end
		endcase
		if (core_evt.dev_reset) begin
			s_d.mode = MODE_RUN;
		end

		s_d.rst_req = (timeout && run) || early;
		s_d.wake = timeout && !run;
		s_d.osc_en = en;
		s_d.low = (s_d.mode != MODE_RUN);

		// register writes; hardware sets win over software clears
		if (wr_rc) begin
			s_d.swen = bus_req.wdata[RC_SWEN];
			s_d.wd_timeout_flag = s_q.wd_timeout_flag && bus_req.wdata[RC_WD_TIMEOUT_FLAG];
			s_d.slp = s_q.slp && bus_req.wdata[RC_SLEEP];
			s_d.idl = s_q.idl && bus_req.wdata[RC_IDLE];
		end
		if (bus_req.wr && wdse_addr_is(bus_req.addr, OFS_CONFIG)) begin
			s_d.cfg = bus_req.wdata;
		end
		if (bus_req.wr && wdse_addr_is(bus_req.addr, OFS_INT_MASK)) begin
			s_d.mask = bus_req.wdata[IRQ_W-1:0];
		end
		if (wr_stat) begin
			s_d.stat = s_q.stat & ~bus_req.wdata[IRQ_W-1:0];
		end
		s_d.stat = s_d.stat | evt_bits;
		if (timeout || early) begin
			s_d.wd_timeout_flag = 1'b1;
		end
		// sleep and idle flags are only ever set here
		if (run && core_evt.power_save_instr) begin
			s_d.slp = s_d.slp || core_evt.power_save_sleep;
			s_d.idl = s_d.idl || !core_evt.power_save_sleep;
		end
		// a watchdog reset is a device reset too
		if (core_evt.dev_reset || s_d.rst_req) begin
			s_d.swen = 1'b0;
		end
		s_d.irq = |(s_d.stat & s_d.mask);

		s_d.rdata = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_RESET_CTRL: begin
					s_d.rdata[RC_SWEN] = s_q.swen;
					s_d.rdata[RC_WD_TIMEOUT_FLAG] = s_q.wd_timeout_flag;
					s_d.rdata[RC_SLEEP] = s_q.slp;
					s_d.rdata[RC_IDLE] = s_q.idl;
				end
				OFS_CONFIG:   s_d.rdata = s_q.cfg;
				OFS_INT_STAT: s_d.rdata[IRQ_W-1:0] = s_q.stat;
				OFS_INT_MASK: s_d.rdata[IRQ_W-1:0] = s_q.mask;
				default:      s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{mode: MODE_RUN, cfg: CONFIG_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign wd_reset_req = s_q.rst_req;
	assign wd_wake = s_q.wake;
	assign osc_enable = s_q.osc_en;
	assign low_power = s_q.low;
	assign irq = s_q.irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sleep_count_a: assert property (
		(s_q.mode == MODE_SLEEP) && low_power_rc_osc_tick && !restart |=> s_q.pre != $past(s_q.pre))
		else $error("prescaler stalled in sleep");

	wake_resume_a: assert property (
		timeout && !run |=> wd_wake && !wd_reset_req && (s_q.mode == MODE_RUN))
		else $error("low power time-out did not wake cleanly");

	flags_kept_a: assert property (
		s_q.slp && !wr_rc |=> s_q.slp)
		else $error("sleep flag cleared by hardware");

	forced_on_a: assert property (
		(en_cfg == EN_ALWAYS) ##1 (en_cfg == EN_ALWAYS) |-> osc_enable)
		else $error("forced enable not running");

	soft_gate_a: assert property (
		(en_cfg == EN_SOFT) && !s_q.swen |=> !osc_enable && (s_q.div == 12'h0))
		else $error("soft disabled watchdog still running");

	swen_reset_a: assert property (
		core_evt.dev_reset |=> !s_q.swen)
		else $error("software enable survived device reset");

	wd_timeout_flag_sticky_a: assert property (
		(timeout || early) ##1 !wr_rc [*2] |-> s_q.wd_timeout_flag)
		else $error("time-out flag lost");

	early_clear_a: assert property (
		early |=> wd_reset_req && s_q.stat[IRQ_EARLY])
		else $error("early clear not punished");

	prescale_a: assert property (
		pre_tick |-> s_q.pre == (s_q.cfg[CF_PRE] ? 7'h7f : 7'h1f))
		else $error("prescaler terminal count wrong");

	postscale_a: assert property (
		timeout |-> 16'(s_q.post) + 16'h1 == (16'h1 << s_q.cfg[3:0]))
		else $error("postscaler ratio wrong");

	restart_a: assert property (
		run && core_evt.clear_wd_instr |=> (s_q.pre == 7'h0) && (s_q.post == 15'h0))
		else $error("clear did not restart counters");

	run_reset_a: assert property (
		timeout && run |=> wd_reset_req && s_q.wd_timeout_flag && !s_q.swen)
		else $error("run time-out did not reset device");

	cov_sleep_wake_c: cover property (s_q.mode == MODE_SLEEP ##[1:1000] wd_wake);
	cov_run_timeout_c: cover property (run && timeout);
	cov_early_c: cover property (early);
	cov_irq_c: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wdse_pkg::*;

	logic              core_clk;
	logic              sys_rst;
	wdse_bus_req_type  bus_req;
	logic [15:0]       bus_rdata;
	wdse_core_evt_type core_evt;
	logic              wd_reset_req;
	logic              wd_wake;
	logic              osc_enable;
	logic              low_power;
	logic              irq;
	int                fails;
	int                tests_run;
	int                cycles;
	int                n;
	logic              hit;

	wdse_watchdog dut (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.bus_req     (bus_req),
		.bus_rdata   (bus_rdata),
		.core_evt    (core_evt),
		.wd_reset_req(wd_reset_req),
		.wd_wake     (wd_wake),
		.osc_enable  (osc_enable),
		.low_power   (low_power),
		.irq         (irq)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// a time-out in sleep takes 100000 cycles, the ceiling leaves margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 130000) begin
			fails++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req.wr    <= 1'b1;
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		bus_req.rd   <= 1'b1;
		bus_req.addr <= a;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 chk(bus_rdata, exp);
	endtask

	task automatic evt(input logic [5:0] m);
		@(posedge core_clk);
		core_evt <= wdse_core_evt_type'(m);
		@(posedge core_clk);
		core_evt <= '0;
	endtask

	// bounded wait on a reset request (sel 0) or a wake pulse (sel 1)
	// the current cycle is looked at first: a pulse launched at the caller's last edge stands now
	task automatic waitsig(input int sel, input int lim, output int cnt, output logic got);
		got = 1'b0;
		for (cnt = 1; cnt <= lim; cnt++) begin
			#1;
			if (sel == 1 && wd_reset_req === 1'b1) chk(16'h1, 16'h0);
			if ((sel == 0) ? wd_reset_req === 1'b1 : wd_wake === 1'b1) begin
				got = 1'b1;
				break;
			end
			@(posedge core_clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		chk(16'(osc_enable), 16'h0);
		wr(4'h2, 16'hffff);
		rd(4'h2, 16'h0000);
		rd(OFS_CONFIG, 16'h209f);
		rd(OFS_RESET_CTRL, 16'h0000);
	endtask

	task automatic s_enable();
		for (int sw = 0; sw < 2; sw++) begin
			wr(OFS_RESET_CTRL, sw ? 16'h0020 : 16'h0000);
			for (int c = 0; c < 4; c++) begin
				wr(OFS_CONFIG, {2'b00, 2'(c), 12'h080});
				repeat (3) @(posedge core_clk);
				#1 chk(16'(osc_enable), 16'((c == 3) || (c == 2 && sw == 1)));
			end
		end
	endtask

	task automatic s_devreset();
		wr(OFS_CONFIG, 16'h2080);
		wr(OFS_RESET_CTRL, 16'h0020);
		rd(OFS_RESET_CTRL, 16'h0020);
		evt(6'h01);
		rd(OFS_RESET_CTRL, 16'h0000);
		repeat (2) @(posedge core_clk);
		#1 chk(16'(osc_enable), 16'h0);
	endtask

	// clearing at the start of the period falls before the window
	task automatic s_window();
		wr(OFS_INT_STAT, 16'h0007);
		wr(OFS_CONFIG, 16'h3004);
		repeat (4) @(posedge core_clk);
		evt(6'h20);
		waitsig(0, 8, n, hit);
		chk(16'(hit), 16'h1);
		wr(OFS_CONFIG, 16'h2080);
		rd(OFS_INT_STAT, 16'h0004);
		chk(16'(irq), 16'h0);
		wr(OFS_INT_MASK, 16'h0004);
		repeat (2) @(posedge core_clk);
		#1 chk(16'(irq), 16'h1);
		rd(OFS_RESET_CTRL, 16'h0010);
		rd(OFS_RESET_CTRL, 16'h0010);
		wr(OFS_RESET_CTRL, 16'h0000);
		rd(OFS_RESET_CTRL, 16'h0000);
		wr(OFS_INT_STAT, 16'h0004);
		repeat (2) @(posedge core_clk);
		#1 chk(16'(irq), 16'h0);
	endtask

	// idle entry, then a clear that idle must ignore, driven in the same cycle as an outside wake source
	task automatic s_idle();
		wr(OFS_CONFIG, 16'h2080);
		evt(6'h10);
		#1 chk(16'(low_power), 16'h1);
		evt(6'h24);
		#1 chk(16'(low_power), 16'h0);
		chk(16'(wd_reset_req), 16'h0);
		chk(16'(wd_wake), 16'h0);
		rd(OFS_RESET_CTRL, 16'h0004);
		wr(OFS_RESET_CTRL, 16'h0000);
		rd(OFS_RESET_CTRL, 16'h0000);
	endtask

	task automatic s_sleep();
		wr(OFS_CONFIG, 16'h2080);
		wr(OFS_RESET_CTRL, 16'h0020);
		wr(OFS_INT_MASK, 16'h0003);
		evt(6'h18);
		@(posedge core_clk);
		#1 chk(16'(low_power), 16'h1);
		rd(OFS_RESET_CTRL, 16'h0028);
		waitsig(1, 110000, n, hit);
		chk(16'(hit), 16'h1);
		chk(16'(n > 96000), 16'h1);
		chk(16'(low_power), 16'h0);
		@(posedge core_clk);
		#1 chk(16'(wd_wake), 16'h0);
		chk(16'(irq), 16'h1);
		rd(OFS_INT_STAT, 16'h0003);
		// a wake is no reset: the soft enable survives, the sleep flag stays for software
		rd(OFS_RESET_CTRL, 16'h0038);
		wr(OFS_RESET_CTRL, 16'h0020);
		rd(OFS_RESET_CTRL, 16'h0020);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst  = 1'b1;
		bus_req  = '0;
		core_evt = '0;
		fails     = 0;
		tests_run = 0;
		cycles    = 0;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1;
		s_reset();
		s_enable();
		s_devreset();
		s_window();
		s_idle();
		s_sleep();
		end_sim();
	end
endmodule
`default_nettype wire
